// ---- common/iope_consts.svh ----
// Constants for the input protection and output enable block.
// Assumes inclusion by bare name from the logic, checker and bench files.
`ifndef IOPE_CONSTS_SVH
`define IOPE_CONSTS_SVH
`define IOPE_A_OPERATION  4'h0
`define IOPE_A_CLEAR      4'h1
`define IOPE_A_UV_OFF     4'h2
`define IOPE_A_UV_ON      4'h3
`define IOPE_A_UV_RESP    4'h4
`define IOPE_A_OV_OFF     4'h5
`define IOPE_A_OV_ON      4'h6
`define IOPE_A_OV_RESP    4'h7
`define IOPE_A_VOUT_CMD   4'h8
`define IOPE_A_VOUT_MAX   4'h9
`define IOPE_A_LOOP_CFG   4'ha
`define IOPE_A_ADAPT      4'hb
`define IOPE_A_STATUS     4'hc
`define IOPE_A_ALERT_MASK 4'hd
`define IOPE_A_VOUT_ACT   4'he
`define IOPE_A_NOMINAL    4'hf
`define IOPE_OP_ON_BIT    7
`define IOPE_OP_PIN_BIT   0
`define IOPE_OP_CMD_BIT   1
`define IOPE_OP_RESET     16'h0001
`define IOPE_RESP_LATCH   1'b0
`define IOPE_RESP_AUTO    1'b1
`define IOPE_UV_OFF_RESET 16'h1b58
`define IOPE_UV_ON_RESET  16'h1c52
`define IOPE_OV_OFF_RESET 16'h3a98
`define IOPE_OV_ON_RESET  16'h3a34
`define IOPE_VMAX_RESET   16'hffff
`define IOPE_LOOP_RESET   16'h0420
`define IOPE_ADAPT_RESET  16'h1000
`define IOPE_MASK_RESET   16'h0000
`define IOPE_ST_UV_BIT    0
`define IOPE_ST_OV_BIT    1
`define IOPE_ST_UV_NOW    2
`define IOPE_ST_OV_NOW    3
`define IOPE_ST_RUN_BIT   4
`define IOPE_ST_OUT_BIT   5
`define IOPE_STRAP_SHORT  5'h00
`define IOPE_STRAP_OPEN   5'h16
`define IOPE_CEIL_PCT     115
`define IOPE_FULL_PCT     100
`define IOPE_GAIN_MAX     8'hff
`define IOPE_GAIN_MIN     8'h01
`endif

// ---- common/iope_pkg.sv ----
// Types shared by the input protection and output enable block.
// Assumes the constants header is on the include path.
package iope_pkg;
  typedef enum logic [1:0] {IOPE_ST_STRAP, IOPE_ST_CONFIG, IOPE_ST_RUN} iope_init_type;
  typedef logic [15:0] iope_word_type;
endpackage

// ---- common/iope_prot_if.sv ----
// Bundle between the top and one input fault channel.
// Assumes a single clock shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface iope_prot_if;
  import iope_pkg::*;
  iope_word_type vin;
  logic          vin_valid;
  iope_word_type off_limit;
  iope_word_type on_limit;
  logic          response;
  logic          armed;
  logic          clear;
  logic          reenable;
  logic          tripped;
  logic          beyond;
  logic          event_pulse;
  modport ctrl (output vin, vin_valid, off_limit, on_limit, response, armed, clear, reenable,
                input tripped, beyond, event_pulse);
  modport chan (input vin, vin_valid, off_limit, on_limit, response, armed, clear, reenable,
                output tripped, beyond, event_pulse);
endinterface
`default_nettype wire

// ---- logic/iope_fault_chan.sv ----
// One input voltage fault channel with hysteresis and selectable response.
// Assumes samples and limits in millivolts on the shared clock.
`timescale 1ns/1ps
`default_nettype none
`include "iope_consts.svh"
module iope_fault_chan import iope_pkg::*; #(
  parameter bit OVER = 1'b0
) (
  input wire logic clock,
  input wire logic reset_n,
  iope_prot_if.chan pif
);
  logic past_off;
  logic inside_on;

  // Over channel trips above the limit, under channel below it
  always_comb begin
    past_off  = OVER ? (pif.vin > pif.off_limit) : (pif.vin < pif.off_limit);
    inside_on = OVER ? (pif.vin < pif.on_limit) : (pif.vin > pif.on_limit);
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pif.tripped     <= 1'b0;
      pif.event_pulse <= 1'b0;
      pif.beyond      <= 1'b0;
    end else begin
      pif.event_pulse <= 1'b0;
      if (pif.vin_valid) begin
        pif.beyond <= past_off;
      end
      if (pif.armed && pif.vin_valid && past_off) begin
        pif.tripped     <= 1'b1;
        pif.event_pulse <= 1'b1;
      end else if (pif.tripped) begin
        if (pif.response == `IOPE_RESP_LATCH) begin
          if (pif.clear || pif.reenable) begin
            pif.tripped <= 1'b0;
          end
        end else if (pif.vin_valid && inside_on) begin
          pif.tripped <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- logic/iope_strap_decode.sv ----
// Decodes the measured strap resistor code into nominal output and ceiling.
// Assumes code 0 is a short, 1 to 20 the listed values, 21 and up open.
`timescale 1ns/1ps
`default_nettype none
`include "iope_consts.svh"
module iope_strap_decode import iope_pkg::*; (
  input  wire logic [4:0]    strap_code,
  output iope_word_type      nominal_mv,
  output iope_word_type      ceiling_mv
);
  logic [31:0] scaled;

  always_comb begin
    unique case (strap_code)
      `IOPE_STRAP_SHORT: nominal_mv = 16'd1000;
      5'h01:   nominal_mv = 16'd600;
      5'h02:   nominal_mv = 16'd650;
      5'h03:   nominal_mv = 16'd700;
      5'h04:   nominal_mv = 16'd750;
      5'h05:   nominal_mv = 16'd800;
      5'h06:   nominal_mv = 16'd850;
      5'h07:   nominal_mv = 16'd900;
      5'h08:   nominal_mv = 16'd950;
      5'h09:   nominal_mv = 16'd1000;
      5'h0a:   nominal_mv = 16'd1050;
      5'h0b:   nominal_mv = 16'd1100;
      5'h0c:   nominal_mv = 16'd1150;
      5'h0d:   nominal_mv = 16'd1200;
      5'h0e:   nominal_mv = 16'd1250;
      5'h0f:   nominal_mv = 16'd1300;
      5'h10:   nominal_mv = 16'd1400;
      5'h11:   nominal_mv = 16'd1500;
      5'h12:   nominal_mv = 16'd1600;
      5'h13:   nominal_mv = 16'd1700;
      5'h14:   nominal_mv = 16'd1800;
      default: nominal_mv = 16'd1200;
    endcase
    // Ceiling is 115 percent of nominal, rounded down to a millivolt
    scaled     = (32'(nominal_mv) * 32'(`IOPE_CEIL_PCT)) / 32'(`IOPE_FULL_PCT);
    ceiling_mv = scaled[15:0];
  end
endmodule
`default_nettype wire

// ---- logic/iope_top.sv ----
// Input protection, output enable, strap decode and loop settings.
// Assumes all inputs synchronous to clock; register port has one-cycle strobes.
//
// Summary of operation
// - Input compared to turn-off and turn-on level (higher for under-, lower for over-voltage), giving hysteresis.
// - Latched mode: under-voltage shuts output until clear-faults or re-enable.
// - Auto mode: output held off until input rises above turn-on level.
// - Fault response defaults to auto-restart after configuration load.
// - Under-voltage limits and response each writable and used by protection.
// - Over-voltage has turn-off limit, warning turn-on limit, own response.
// - Output enabled either by enable pin or operation command, host chooses.
// - Enable pin pulled up; unconnected pin reads as high.
// - Strap code decodes to 0.60 to 1.80 V; short 1.00, open 1.20.
// - Strap sampled only at initialization; later changes ignored.
// - Strap value also sets ceiling on regulated output.
// - Gain and residual factors set by one loop configuration register.
// - Charge control reacts to current change within one switching cycle.
// - Adaptive compensation excites, measures response, retunes loop gain.
// - Ceiling is 115 percent of nominal, lowerable by maximum-voltage register.
// - Strap value loads setpoint; later nonzero user setpoint overwrites it.
// - Unmasked faults pull alert low until clear-faults or re-enable.
`timescale 1ns/1ps
`default_nettype none
`include "iope_consts.svh"
module iope_top import iope_pkg::*; #(
  parameter int EXCITE_PERIOD = 64,
  parameter int EXCITE_LEN    = 4
) (
  input  wire logic         clock,
  input  wire logic         reset_n,
  input  wire logic [3:0]   reg_addr,
  input  wire logic [15:0]  reg_wdata,
  input  wire logic         reg_write,
  input  wire logic         reg_read,
  output logic [15:0]       reg_rdata,
  input  wire logic [15:0]  vin_mv,
  input  wire logic         vin_valid,
  input  wire logic [4:0]   strap_code,
  input  wire logic         strap_valid,
  input  wire logic         user_cfg_valid,
  input  wire logic [15:0]  user_vout_mv,
  input  wire logic         enable_pin,
  input  wire logic         pwm_tick,
  input  wire logic [15:0]  iout_ma,
  input  wire logic [15:0]  vout_mv,
  output logic              output_enable,
  output logic [15:0]       vout_target_mv,
  output logic              alert_out_n,
  output logic [7:0]        loop_gain,
  output logic [7:0]        loop_residual,
  output logic signed [15:0] charge_step,
  output logic              excite
);
  iope_init_type init_state;
  iope_word_type op_reg;
  iope_word_type uv_off;
  iope_word_type uv_on;
  logic          uv_resp;
  iope_word_type ov_off;
  iope_word_type ov_on;
  logic          ov_resp;
  iope_word_type vout_cmd;
  iope_word_type vout_max;
  iope_word_type loop_cfg;
  iope_word_type adapt_cfg;
  iope_word_type alert_mask;
  iope_word_type nominal;
  iope_word_type ceiling;
  iope_word_type dec_nominal;
  iope_word_type dec_ceiling;
  logic [1:0]    fault_flags;
  logic          clear_cmd;
  logic          en_req;
  logic          en_req_d;
  logic          reenable;
  logic          running;
  iope_word_type limit;
  iope_word_type next_target;
  logic [15:0]   iout_prev;
  logic signed [16:0] i_delta;
  logic signed [25:0] i_prod;
  logic [15:0]   excite_cnt;
  logic [15:0]   vout_base;
  logic [15:0]   vout_dev;
  logic          wr;
  logic          gain_load;

  iope_prot_if uv_if ();
  iope_prot_if ov_if ();

  iope_fault_chan #(.OVER(1'b0)) u_uv (
    .clock   (clock),
    .reset_n (reset_n),
    .pif     (uv_if.chan)
  );
  iope_fault_chan #(.OVER(1'b1)) u_ov (
    .clock   (clock),
    .reset_n (reset_n),
    .pif     (ov_if.chan)
  );
  iope_strap_decode u_strap (
    .strap_code (strap_code),
    .nominal_mv (dec_nominal),
    .ceiling_mv (dec_ceiling)
  );

  assign wr        = reg_write && !reg_read;
  assign clear_cmd = wr && (reg_addr == `IOPE_A_CLEAR);
  assign gain_load = wr && (reg_addr == `IOPE_A_LOOP_CFG);
  assign running   = (init_state == IOPE_ST_RUN);

  // Open pin reads high, so pin control defaults to on
  always_comb begin
    if (op_reg[`IOPE_OP_PIN_BIT]) begin
      en_req = enable_pin;
    end else if (op_reg[`IOPE_OP_CMD_BIT]) begin
      en_req = op_reg[`IOPE_OP_ON_BIT];
    end else begin
      en_req = 1'b0;
    end
  end
  assign reenable = en_req && !en_req_d;

  // Channel wiring
  assign uv_if.vin       = vin_mv;
  assign uv_if.vin_valid = vin_valid;
  assign uv_if.off_limit = uv_off;
  assign uv_if.on_limit  = uv_on;
  assign uv_if.response  = uv_resp;
  assign uv_if.armed     = running;
  assign uv_if.clear     = clear_cmd;
  assign uv_if.reenable  = reenable;
  assign ov_if.vin       = vin_mv;
  assign ov_if.vin_valid = vin_valid;
  assign ov_if.off_limit = ov_off;
  assign ov_if.on_limit  = ov_on;
  assign ov_if.response  = ov_resp;
  assign ov_if.armed     = running;
  assign ov_if.clear     = clear_cmd;
  assign ov_if.reenable  = reenable;

  // Initialization sequence
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      init_state <= IOPE_ST_STRAP;
      nominal    <= 16'h0000;
      ceiling    <= 16'h0000;
    end else begin
      unique case (init_state)
        IOPE_ST_STRAP: begin
          if (strap_valid) begin
            nominal    <= dec_nominal;
            ceiling    <= dec_ceiling;
            init_state <= IOPE_ST_CONFIG;
          end
        end
        IOPE_ST_CONFIG: begin
          if (user_cfg_valid) begin
            init_state <= IOPE_ST_RUN;
          end
        end
        IOPE_ST_RUN: begin
          init_state <= IOPE_ST_RUN;
        end
      endcase
    end
  end

  // Setpoint: strap first, user configuration or bus afterwards
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      vout_cmd <= 16'h0000;
    end else if (init_state == IOPE_ST_STRAP && strap_valid) begin
      vout_cmd <= dec_nominal;
    end else if (init_state == IOPE_ST_CONFIG && user_cfg_valid
                 && user_vout_mv != 16'h0000) begin
      vout_cmd <= user_vout_mv;
    end else if (running && wr && reg_addr == `IOPE_A_VOUT_CMD) begin
      vout_cmd <= reg_wdata;
    end
  end

  // Protection settings and control registers
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      op_reg     <= `IOPE_OP_RESET;
      uv_off     <= `IOPE_UV_OFF_RESET;
      uv_on      <= `IOPE_UV_ON_RESET;
      uv_resp    <= `IOPE_RESP_AUTO;
      ov_off     <= `IOPE_OV_OFF_RESET;
      ov_on      <= `IOPE_OV_ON_RESET;
      ov_resp    <= `IOPE_RESP_AUTO;
      vout_max   <= `IOPE_VMAX_RESET;
      loop_cfg   <= `IOPE_LOOP_RESET;
      adapt_cfg  <= `IOPE_ADAPT_RESET;
      alert_mask <= `IOPE_MASK_RESET;
    end else if (wr) begin
      unique case (reg_addr)
        `IOPE_A_OPERATION:  op_reg     <= reg_wdata;
        `IOPE_A_UV_OFF:     uv_off     <= reg_wdata;
        `IOPE_A_UV_ON:      uv_on      <= reg_wdata;
        `IOPE_A_UV_RESP:    uv_resp    <= reg_wdata[0];
        `IOPE_A_OV_OFF:     ov_off     <= reg_wdata;
        `IOPE_A_OV_ON:      ov_on      <= reg_wdata;
        `IOPE_A_OV_RESP:    ov_resp    <= reg_wdata[0];
        `IOPE_A_VOUT_MAX:   vout_max   <= reg_wdata;
        `IOPE_A_LOOP_CFG:   loop_cfg   <= reg_wdata;
        `IOPE_A_ADAPT:      adapt_cfg  <= reg_wdata;
        `IOPE_A_ALERT_MASK: alert_mask <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Sticky input fault flags; a new event beats clear-faults
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      fault_flags <= 2'b00;
    end else begin
      fault_flags <= (clear_cmd ? 2'b00 : fault_flags)
                     | {ov_if.event_pulse, uv_if.event_pulse};
    end
  end

  // Alert low from an unmasked fault event until clear-faults or re-enable
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      alert_out_n <= 1'b1;
    end else if ((uv_if.event_pulse && !alert_mask[`IOPE_ST_UV_BIT])
                 || (ov_if.event_pulse && !alert_mask[`IOPE_ST_OV_BIT])) begin
      alert_out_n <= 1'b0;
    end else if (clear_cmd || reenable) begin
      alert_out_n <= 1'b1;
    end
  end

  // Output enable and regulated target
  always_comb begin
    limit       = (vout_max < ceiling) ? vout_max : ceiling;
    next_target = (vout_cmd < limit) ? vout_cmd : limit;
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      en_req_d       <= 1'b0;
      output_enable  <= 1'b0;
      vout_target_mv <= 16'h0000;
    end else begin
      en_req_d       <= running && en_req;
      output_enable  <= running && en_req && !uv_if.tripped && !ov_if.tripped
                        && !(vin_valid && (uv_if.beyond || ov_if.beyond) && 1'b0);
      vout_target_mv <= next_target;
    end
  end

  // Charge control step, updated every switching cycle
  always_comb begin
    i_delta = $signed({1'b0, iout_ma}) - $signed({1'b0, iout_prev});
    i_prod  = i_delta * $signed({1'b0, loop_gain});
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      iout_prev   <= 16'h0000;
      charge_step <= 16'sh0000;
    end else if (pwm_tick) begin
      iout_prev   <= iout_ma;
      charge_step <= $signed(i_prod[23:8]) - (charge_step >>> loop_residual[3:0]);
    end
  end

  // Adaptive compensation: periodic excitation and gain retune
  always_comb begin
    vout_dev = (vout_mv > vout_base) ? (vout_mv - vout_base) : (vout_base - vout_mv);
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      excite_cnt    <= 16'h0000;
      excite        <= 1'b0;
      vout_base     <= 16'h0000;
      loop_gain     <= 8'(`IOPE_LOOP_RESET & 16'h00ff);
      loop_residual <= 8'(`IOPE_LOOP_RESET >> 8);
    end else if (gain_load) begin
      loop_gain     <= reg_wdata[7:0];
      loop_residual <= reg_wdata[15:8];
      excite_cnt    <= 16'h0000;
      excite        <= 1'b0;
    end else if (pwm_tick && adapt_cfg[0] && output_enable) begin
      if (excite_cnt == 16'(EXCITE_PERIOD - 1)) begin
        excite_cnt <= 16'h0000;
        excite     <= 1'b1;
        vout_base  <= vout_mv;
      end else begin
        excite_cnt <= excite_cnt + 16'h0001;
        if (excite && excite_cnt == 16'(EXCITE_LEN - 1)) begin
          excite <= 1'b0;
          if (vout_dev > {8'h00, adapt_cfg[15:8]} && loop_gain != `IOPE_GAIN_MAX) begin
            loop_gain <= loop_gain + 8'h01;
          end else if (vout_dev < {8'h00, adapt_cfg[15:8]}
                       && loop_gain != `IOPE_GAIN_MIN) begin
            loop_gain <= loop_gain - 8'h01;
          end
        end
      end
    end else if (!adapt_cfg[0]) begin
      excite     <= 1'b0;
      excite_cnt <= 16'h0000;
    end
  end

  // Read port, data valid one cycle after the strobe
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_read) begin
      unique case (reg_addr)
        `IOPE_A_OPERATION:  reg_rdata <= op_reg;
        `IOPE_A_UV_OFF:     reg_rdata <= uv_off;
        `IOPE_A_UV_ON:      reg_rdata <= uv_on;
        `IOPE_A_UV_RESP:    reg_rdata <= {15'h0000, uv_resp};
        `IOPE_A_OV_OFF:     reg_rdata <= ov_off;
        `IOPE_A_OV_ON:      reg_rdata <= ov_on;
        `IOPE_A_OV_RESP:    reg_rdata <= {15'h0000, ov_resp};
        `IOPE_A_VOUT_CMD:   reg_rdata <= vout_cmd;
        `IOPE_A_VOUT_MAX:   reg_rdata <= vout_max;
        `IOPE_A_LOOP_CFG:   reg_rdata <= {loop_residual, loop_gain};
        `IOPE_A_ADAPT:      reg_rdata <= adapt_cfg;
        `IOPE_A_STATUS:     reg_rdata <= {10'h000, output_enable, running,
                                          ov_if.tripped, uv_if.tripped, fault_flags};
        `IOPE_A_ALERT_MASK: reg_rdata <= alert_mask;
        `IOPE_A_VOUT_ACT:   reg_rdata <= vout_target_mv;
        `IOPE_A_NOMINAL:    reg_rdata <= nominal;
        default:            reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// ---- sim/iope_host_model.sv ----
// Host side of the enable pin: drives it low on request, else releases it.
// Assumes the bench requests levels on the block clock.
`timescale 1ns/1ps
`default_nettype none
module iope_host_model (
  input  wire logic clock,
  input  wire logic pin_low,
  output logic      enable_pin
);
  logic drive_q = 1'b0;
  // Pin moves only on a clock edge; clock is stable from time zero
  always @(posedge clock) drive_q <= pin_low;
  // Bench picks pin or command as the one enable method
  // Released pin reads high through the pull-up
  assign enable_pin = drive_q ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ---- sim/iope_top_sva.sv ----
// Checker on the top ports of the protection and enable block.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "iope_consts.svh"
module iope_top_sva (
  input wire logic               clock,
  input wire logic               reset_n,
  input wire logic [3:0]         reg_addr,
  input wire logic [15:0]        reg_wdata,
  input wire logic               reg_write,
  input wire logic               reg_read,
  input wire logic [15:0]        reg_rdata,
  input wire logic [15:0]        vin_mv,
  input wire logic               vin_valid,
  input wire logic               enable_pin,
  input wire logic               pwm_tick,
  input wire logic               output_enable,
  input wire logic               alert_out_n,
  input wire logic [7:0]         loop_gain,
  input wire logic [7:0]         loop_residual,
  input wire logic signed [15:0] charge_step
);
  logic [15:0] uv_off;
  logic [15:0] ov_off;
  logic [3:0]  clr_hist;
  logic        pin_src;
  logic        pin_q;
  wire         wr_ok = reg_write && !reg_read;
  wire         clr_now = wr_ok && (reg_addr == `IOPE_A_CLEAR || reg_addr == `IOPE_A_OPERATION);
  // Shadow of the limits and enable source
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      uv_off  <= `IOPE_UV_OFF_RESET;
      ov_off  <= `IOPE_OV_OFF_RESET;
      pin_src <= 1'b1;
    end else if (wr_ok) begin
      if (reg_addr == `IOPE_A_UV_OFF) uv_off <= reg_wdata;
      if (reg_addr == `IOPE_A_OV_OFF) ov_off <= reg_wdata;
      if (reg_addr == `IOPE_A_OPERATION) pin_src <= reg_wdata[`IOPE_OP_PIN_BIT];
    end
  end
  // Recent clear or re-enable events
  always_ff @(posedge clock) begin
    pin_q    <= enable_pin;
    clr_hist <= {clr_hist[2:0], clr_now || (enable_pin && !pin_q)};
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside its cycle");
  a_uv_trip_off: assert property (
    vin_valid && vin_mv < uv_off && output_enable |-> ##2 !output_enable)
    else $error("output not off after low input");
  a_ov_trip_off: assert property (
    vin_valid && vin_mv > ov_off && output_enable |-> ##2 !output_enable)
    else $error("output not off after high input");
  a_alert_cause: assert property ($fell(alert_out_n) |-> $past(vin_valid, 2))
    else $error("alert fell without input sample");
  a_alert_hold: assert property ($rose(alert_out_n) |-> |clr_hist)
    else $error("alert released without clear or enable");
  a_pin_off: assert property ($fell(enable_pin) && pin_src |-> ##[1:3] !output_enable)
    else $error("output stayed on after pin low");
  a_loop_write: assert property (
    wr_ok && reg_addr == `IOPE_A_LOOP_CFG |=> {loop_residual, loop_gain} == $past(reg_wdata))
    else $error("loop factors not taken from write");
  a_charge_quiet: assert property (!$past(pwm_tick) |-> $stable(charge_step))
    else $error("charge step moved without switching tick");
  c_uv_trip: cover property (vin_valid && vin_mv < uv_off && output_enable);
  c_ov_trip: cover property (vin_valid && vin_mv > ov_off && output_enable);
  c_alert_clr: cover property ($rose(alert_out_n));
endmodule
bind iope_top iope_top_sva u_sva (.*);
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench: strap decode, input faults, enable sources, loop settings.
// Assumes the host model on the enable pin and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "iope_consts.svh"
module testbench;
  logic [15:0] reg_wdata = '0, vin_mv = '0, user_vout_mv = '0, iout_ma = '0, vout_mv = '0;
  logic [15:0] reg_rdata, vout_target_mv, d;
  logic [7:0]  loop_gain, loop_residual;
  logic [4:0]  strap_code = '0;
  logic [3:0]  reg_addr = '0;
  logic        clock = 0, reset_n = 0, reg_write = 0, reg_read = 0, vin_valid = 0;
  logic        strap_valid = 0, user_cfg_valid = 0, pwm_tick = 0, pin_low = 0;
  logic        enable_pin, output_enable, alert_out_n, excite;
  logic signed [15:0] charge_step;
  int          fails = 0, n_checks = 0, uv_off, uv_on, ov_off, ov_on;
  bit          uv_auto, ov_auto, uv_tr, ov_tr, uv_fl, ov_fl, al, en, psrc, um, cs_on = 1;
  shortint     cs_e = 0;
  int          ip_e = 0;
  logic [15:0] lc = `IOPE_LOOP_RESET;
  int          tbl[20] = '{600, 650, 700, 750, 800, 850, 900, 950, 1000, 1050, 1100, 1150,
                           1200, 1250, 1300, 1400, 1500, 1600, 1700, 1800};
  logic [4:0]  codes[5] = '{5'h00, 5'h01, 5'h14, 5'h16, 5'h1f};
  iope_top #(.EXCITE_PERIOD(8), .EXCITE_LEN(2)) u_dut (.*);
  iope_host_model u_host (.clock(clock), .pin_low(pin_low), .enable_pin(enable_pin));
  initial forever #2 clock = ~clock;
  always @(posedge clock) begin
    pwm_tick <= ($urandom % 4) == 0;
    iout_ma <= 16'($urandom % 20000);
    vout_mv <= 16'($urandom % 2000);
  end
  // Charge step model, checked at every switching tick while cs_on is set
  always @(posedge clock) begin
    if (!reset_n) begin
      cs_e = 0;
      ip_e = 0;
      lc = `IOPE_LOOP_RESET;
    end else if (pwm_tick) begin
      if (cs_on) chk("charge_step", cs_e, charge_step);
      cs_e = shortint'((((int'(iout_ma) - ip_e) * int'(lc[7:0])) >>> 8) - (cs_e >>> lc[11:8]));
      ip_e = iout_ma;
    end
    if (reset_n && reg_write && reg_addr == `IOPE_A_LOOP_CFG) lc = reg_wdata;
  end
  function automatic int nom(logic [4:0] c);
    if (c == 5'h00) return 1000;
    if (c > 5'h14) return 1200;
    return tbl[int'(c) - 1];
  endfunction
  task automatic test_done;
    if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [15:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1;
    @(posedge clock);
    reg_write <= 0;
    if (a == `IOPE_A_CLEAR) {uv_fl, ov_fl, al, uv_tr, ov_tr} = {3'h0, uv_tr & uv_auto, ov_tr & ov_auto};
  endtask
  task automatic rd(logic [3:0] a, string nm, logic [15:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1;
    @(posedge clock);
    reg_read <= 0;
    #1 chk(nm, e, reg_rdata);
  endtask
  task automatic look;
    repeat (3) @(posedge clock);
    #1 chk("output_enable", {15'h0, en & !uv_tr & !ov_tr}, {15'h0, output_enable});
    chk("alert_out_n", {15'h0, !al}, {15'h0, alert_out_n});
    rd(`IOPE_A_STATUS, "status", {10'h0, en & !uv_tr & !ov_tr, 1'b1, ov_tr, uv_tr, ov_fl, uv_fl});
  endtask
  task automatic samp(int v);
    @(posedge clock);
    vin_mv <= 16'(v);
    vin_valid <= 1;
    @(posedge clock);
    vin_valid <= 0;
    if (v < uv_off) {uv_tr, uv_fl, al} = {2'h3, al | !um};
    else if (uv_auto && v > uv_on) uv_tr = 0;
    if (v > ov_off) {ov_tr, ov_fl, al} = 3'h7;
    else if (ov_auto && v < ov_on) ov_tr = 0;
    look();
  endtask
  task automatic pin(bit lo);
    @(posedge clock);
    pin_low <= lo;
    repeat (2) @(posedge clock);
    if (psrc && !lo && !en) {uv_tr, ov_tr, al} = {uv_tr & uv_auto, ov_tr & ov_auto, 1'b0};
    if (psrc) en = !lo;
    look();
  endtask
  task automatic op(logic [15:0] v);
    wr(`IOPE_A_OPERATION, v);
    psrc = v[0];
    en = v[0] ? !pin_low : v[1] & v[7];
    look();
  endtask
  task automatic boot(logic [4:0] c, logic [15:0] u);
    @(posedge clock);
    reset_n <= 0;
    strap_code <= c;
    user_vout_mv <= u;
    repeat (16) @(posedge clock);
    reset_n <= 1;
    @(posedge clock);
    strap_valid <= 1;
    @(posedge clock);
    strap_valid <= 0;
    user_cfg_valid <= 1;
    @(posedge clock);
    user_cfg_valid <= 0;
    {uv_off, uv_on, ov_off, ov_on} = {32'd7000, 32'd7250, 32'd15000, 32'd14900};
    {uv_auto, ov_auto, uv_tr, ov_tr, uv_fl, ov_fl, al, psrc} = 8'hc1;
    en = !pin_low;
  endtask
  initial begin
    void'($urandom(32'h475fabbf));
    foreach (codes[i]) begin
      boot(codes[i], 16'h0000);
      rd(`IOPE_A_NOMINAL, "nominal", 16'(nom(codes[i])));
      rd(`IOPE_A_VOUT_ACT, "target", 16'(nom(codes[i])));
      chk("target pin", 16'(nom(codes[i])), vout_target_mv);
      wr(`IOPE_A_VOUT_CMD, 16'hffff);
      rd(`IOPE_A_VOUT_ACT, "ceiling", 16'(nom(codes[i]) * 115 / 100));
    end
    boot(5'h14, 16'h05dc);
    rd(`IOPE_A_VOUT_ACT, "user target", 16'h05dc);
    wr(`IOPE_A_VOUT_MAX, 16'h0578);
    rd(`IOPE_A_VOUT_ACT, "vout max", 16'h0578);
    @(posedge clock);
    strap_code <= 5'h00;
    strap_valid <= 1;
    @(posedge clock);
    strap_valid <= 0;
    rd(`IOPE_A_NOMINAL, "late strap", 16'h0708);
    rd(`IOPE_A_UV_RESP, "uv resp", 16'(`IOPE_RESP_AUTO));
    rd(`IOPE_A_OV_RESP, "ov resp", 16'(`IOPE_RESP_AUTO));
    boot(5'h01, 16'h0000);
    samp(10000);
    samp(6900);
    samp(7100);
    samp(7300);
    wr(`IOPE_A_CLEAR, 16'h0000);
    samp(10000);
    samp(15001);
    samp(14950);
    samp(14000);
    wr(`IOPE_A_CLEAR, 16'h0000);
    wr(`IOPE_A_UV_RESP, 16'(`IOPE_RESP_LATCH));
    uv_auto = 0;
    samp(6999);
    samp(12000);
    wr(`IOPE_A_CLEAR, 16'h0000);
    samp(12000);
    wr(`IOPE_A_UV_OFF, 16'h1f40);
    uv_off = 8000;
    samp(7900);
    wr(`IOPE_A_OV_RESP, 16'(`IOPE_RESP_LATCH));
    ov_auto = 0;
    samp(15500);
    samp(12000);
    pin(1);
    pin(0);
    wr(`IOPE_A_CLEAR, 16'h0000);
    op(16'h0082);
    pin(1);
    op(16'h0002);
    op(16'h0001);
    pin(0);
    wr(`IOPE_A_ALERT_MASK, 16'h0001);
    um = 1;
    samp(6000);
    pin(1);
    pin(0);
    repeat (4) begin
      d = {8'($urandom), 8'($urandom_range(255, 1))};
      wr(`IOPE_A_LOOP_CFG, d);
      #1 chk("loop cfg", d, {loop_residual, loop_gain});
    end
    cs_on = 0;
    wr(`IOPE_A_ADAPT, 16'h0101);
    for (int i = 0; i < 2000 && excite !== 1'b1; i++) @(posedge clock);
    chk("excite", 16'h0001, {15'h0, excite});
    test_done();
  end
  initial begin
    repeat (100000) @(posedge clock);
    fails++;
    test_done();
  end
endmodule
`default_nettype wire
